// [pkg/serial_read_regs.svh]
`ifndef SERIAL_READ_REGS_SVH
`define SERIAL_READ_REGS_SVH

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define RD_PTR_RESET      8'h00
`define LINE_IDLE_LEVEL   1'b1
`define TX_SHIFT_RESET    8'hFF

// ----------------------------------------------------------------------
// byte framing counts
// ----------------------------------------------------------------------
`define BIT_COUNT_ZERO    4'h0
`define BIT_COUNT_LAST    4'h7
`define BIT_COUNT_FULL    4'h8

// ----------------------------------------------------------------------
// field positions of the select byte
// ----------------------------------------------------------------------
`define SEL_DIR_BIT       0
`define SEL_ID_MSB        7
`define SEL_ID_LSB        1

`endif

// [pkg/serial_read_pkg.sv]
package serial_read_pkg;

  // --------------------------------------------------------------------
  // protocol states
  // --------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RX,
    ST_ACK_ON,
    ST_ACK_OFF,
    ST_TX,
    ST_TX_ACK,
    ST_TX_LOAD
  } state_t;

  // --------------------------------------------------------------------
  // meaning of the byte being received
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {
    PH_SELECT,
    PH_ADDRESS,
    PH_WDATA
  } phase_t;

  // --------------------------------------------------------------------
  // read port toward the storage
  // --------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic       space;
    logic       en;
  } rd_req_t;

  // --------------------------------------------------------------------
  // all state of the target apart from the received byte in serial_shift_in
  // --------------------------------------------------------------------
  typedef struct packed {
    logic       scl_m;
    logic       scl_s;
    logic       scl_p;
    logic       sda_m;
    logic       sda_s;
    logic       sda_p;
    state_t     st;
    phase_t     phase;
    logic [3:0] cnt;
    logic [7:0] ptr;
    logic       space;
    logic       tx_next;
    logic [7:0] tx_sh;
    logic       oe;
    logic       rd_en;
  } ctl_t;

endpackage

// [logic/serial_shift_in.sv]
`timescale 1ns/100ps

// ----------------------------------------------------------------------
// serial shifter on the link clock
// ----------------------------------------------------------------------
module serial_shift_in (
  input  wire logic       scl_clk_i,
  input  wire logic       sda_i,
  output logic      [7:0] byte_o
);

  // data only, no reset: read after eight rises
  always_ff @(posedge scl_clk_i) begin
    byte_o <= {byte_o[6:0], sda_i};
  end

endmodule

// [logic/serial_read_target.sv]
`timescale 1ns/100ps
`include "serial_read_regs.svh"

// Behaviour
// - the target acks the first select, the address and the second select.
// - data bytes keep coming while the master acks the ninth clock of a byte.
// - the pointer loads from the address byte and steps by one per byte sent.
// - reads past the end of a section return whatever lies there, no wrap.
// - every byte travels most significant bit first.
// - the pointer clears to zero at reset, so a plain read starts at zero.
// - the select field must match one of two identifiers to be acked.
module serial_read_target #(
  // identifiers: arbitrary values
  parameter logic [6:0] ID_CLOCK = 7'h2A,
  parameter logic [6:0] ID_STORE = 7'h2B
) (
  input  wire logic                     clk_i,
  input  wire logic                     sys_rst_i,
  input  wire logic                     scl_clk_i,
  input  wire logic                     scl_i,
  input  wire logic                     sda_i,
  output logic                          sda_o,
  output logic                          sda_oe_o,
  output serial_read_pkg::rd_req_t      rd_req_o,
  input  wire logic               [7:0] rd_data_i,
  output logic                          busy_o
);

  // --------------------------------------------------------------------
  // reset image
  // --------------------------------------------------------------------
  localparam serial_read_pkg::ctl_t CTL_RESET = '{
    scl_m   : `LINE_IDLE_LEVEL,
    scl_s   : `LINE_IDLE_LEVEL,
    scl_p   : `LINE_IDLE_LEVEL,
    sda_m   : `LINE_IDLE_LEVEL,
    sda_s   : `LINE_IDLE_LEVEL,
    sda_p   : `LINE_IDLE_LEVEL,
    st      : serial_read_pkg::ST_IDLE,
    phase   : serial_read_pkg::PH_SELECT,
    cnt     : `BIT_COUNT_ZERO,
    ptr     : `RD_PTR_RESET,
    space   : 1'b0,
    tx_next : 1'b0,
    tx_sh   : `TX_SHIFT_RESET,
    oe      : 1'b0,
    rd_en   : 1'b0
  };

  serial_read_pkg::ctl_t s;
  serial_read_pkg::ctl_t next_s;

  logic [7:0] rx_byte;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_seen;
  logic       stop_seen;
  logic [6:0] sel_id;
  logic       sel_dir;
  logic       hit_clock;
  logic       hit_store;

  // --------------------------------------------------------------------
  // link clock side: bits shift in msb first
  // --------------------------------------------------------------------
  serial_shift_in u_shift (
    .scl_clk_i (scl_clk_i),
    .sda_i     (sda_i),
    .byte_o    (rx_byte)
  );

  // --------------------------------------------------------------------
  // line events from synchronised copies
  // --------------------------------------------------------------------
  assign scl_rise   = s.scl_s & ~s.scl_p;
  assign scl_fall   = ~s.scl_s & s.scl_p;
  assign start_seen = s.scl_s & s.scl_p & s.sda_p & ~s.sda_s;
  assign stop_seen  = s.scl_s & s.scl_p & ~s.sda_p & s.sda_s;

  // --------------------------------------------------------------------
  // select byte decode
  // --------------------------------------------------------------------
  assign sel_id    = rx_byte[`SEL_ID_MSB:`SEL_ID_LSB];
  assign sel_dir   = rx_byte[`SEL_DIR_BIT];
  assign hit_clock = (sel_id == ID_CLOCK);
  assign hit_store = (sel_id == ID_STORE);

  // --------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------
  always_comb begin
    logic load_byte;
    load_byte    = 1'b0;
    next_s       = s;
    next_s.rd_en = 1'b0;
    next_s.scl_m = scl_i;
    next_s.scl_s = s.scl_m;
    next_s.scl_p = s.scl_s;
    next_s.sda_m = sda_i;
    next_s.sda_s = s.sda_m;
    next_s.sda_p = s.sda_s;

    if (stop_seen) begin
      next_s.st  = serial_read_pkg::ST_IDLE;
      next_s.oe  = 1'b0;
    end else if (start_seen) begin
      // start or repeated start: a select byte follows
      next_s.st    = serial_read_pkg::ST_RX;
      next_s.phase = serial_read_pkg::PH_SELECT;
      next_s.cnt   = `BIT_COUNT_ZERO;
      next_s.oe    = 1'b0;
    end else begin
      unique case (s.st)
        serial_read_pkg::ST_IDLE: begin
          next_s.oe = 1'b0;
        end

        serial_read_pkg::ST_RX: begin
          if (scl_rise) begin
            next_s.cnt = s.cnt + 4'h1;
            if (s.cnt == `BIT_COUNT_LAST) begin
              unique case (s.phase)
                serial_read_pkg::PH_SELECT: begin
                  if (hit_clock || hit_store) begin
                    next_s.space   = hit_store;
                    next_s.tx_next = sel_dir;
                    next_s.phase   = serial_read_pkg::PH_ADDRESS;
                    next_s.st      = serial_read_pkg::ST_ACK_ON;
                  end else begin
                    next_s.st = serial_read_pkg::ST_IDLE;
                  end
                end
                serial_read_pkg::PH_ADDRESS: begin
                  next_s.ptr     = rx_byte;
                  next_s.tx_next = 1'b0;
                  next_s.phase   = serial_read_pkg::PH_WDATA;
                  next_s.st      = serial_read_pkg::ST_ACK_ON;
                end
                default: begin
                  // write data belongs to the write path
                  next_s.st = serial_read_pkg::ST_IDLE;
                end
              endcase
            end
          end
        end

        serial_read_pkg::ST_ACK_ON: begin
          if (scl_fall) begin
            next_s.oe = 1'b1;
            next_s.st = serial_read_pkg::ST_ACK_OFF;
          end
        end

        serial_read_pkg::ST_ACK_OFF: begin
          if (scl_fall) begin
            next_s.cnt = `BIT_COUNT_ZERO;
            if (s.tx_next) begin
              load_byte = 1'b1;
            end else begin
              next_s.oe = 1'b0;
              next_s.st = serial_read_pkg::ST_RX;
            end
          end
        end

        serial_read_pkg::ST_TX: begin
          if (scl_rise) begin
            next_s.cnt = s.cnt + 4'h1;
          end else if (scl_fall) begin
            if (s.cnt == `BIT_COUNT_FULL) begin
              next_s.oe = 1'b0;
              next_s.st = serial_read_pkg::ST_TX_ACK;
            end else begin
              next_s.tx_sh = {s.tx_sh[6:0], 1'b1};
              next_s.oe    = ~s.tx_sh[6];
            end
          end
        end

        serial_read_pkg::ST_TX_ACK: begin
          if (scl_rise) begin
            if (!s.sda_s) begin
              next_s.st = serial_read_pkg::ST_TX_LOAD;
            end else begin
              next_s.oe = 1'b0;
              next_s.st = serial_read_pkg::ST_IDLE;
            end
          end
        end

        serial_read_pkg::ST_TX_LOAD: begin
          if (scl_fall) begin
            next_s.cnt = `BIT_COUNT_ZERO;
            load_byte  = 1'b1;
          end
        end
      endcase
    end

    if (load_byte) begin
      // pointer counts plainly, no section wrap
      next_s.tx_sh = rd_data_i;
      next_s.oe    = ~rd_data_i[7];
      next_s.ptr   = s.ptr + 8'h01;
      next_s.rd_en = 1'b1;
      next_s.st    = serial_read_pkg::ST_TX;
    end
  end

  // --------------------------------------------------------------------
  // state register
  // --------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      s <= CTL_RESET;
    end else begin
      s <= next_s;
    end
  end

  // --------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------
  assign sda_o          = 1'b0;
  assign sda_oe_o       = s.oe;
  assign rd_req_o       = '{addr: s.ptr, space: s.space, en: s.rd_en};
  assign busy_o         = (s.st != serial_read_pkg::ST_IDLE);

endmodule

// [verification/serial_read_props.sv]
`timescale 1ns/100ps

// ----------------------------------------------------------------------
// target port checks
// ----------------------------------------------------------------------
module serial_read_props (
  input wire logic                     clk_i,
  input wire logic                     sys_rst_i,
  input wire logic                     scl_i,
  input wire logic                     sda_o,
  input wire logic                     sda_oe_o,
  input wire serial_read_pkg::rd_req_t rd_req_o,
  input wire logic                     busy_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_load_pulse;
    rd_req_o.en ##1 !rd_req_o.en;
  endsequence

  a_load_once: assert property (rd_req_o.en |-> s_load_pulse)
    else $error("load strobe wider than one cycle");
  a_ptr_step: assert property (
    rd_req_o.en |-> rd_req_o.addr == $past(rd_req_o.addr) + 8'h01)
    else $error("pointer did not step by one");
  a_idle_release: assert property (!busy_o |-> !sda_oe_o)
    else $error("data line held while idle");
  a_idle_no_load: assert property (!busy_o |-> !rd_req_o.en)
    else $error("load while idle");
  a_pull_low: assert property (sda_oe_o |-> sda_o == 1'b0)
    else $error("driven level not low");
  a_change_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i)
    else $error("data line moved while clock high");
  a_reset_clear: assert property (
    $fell(sys_rst_i) |-> rd_req_o.addr == 8'h00 && !busy_o)
    else $error("pointer not zero after reset");
  a_oe_hold: assert property (
    $rose(sda_oe_o) |-> (busy_o && sda_oe_o)[*8])
    else $error("drive too short");
endmodule

bind serial_read_target serial_read_props u_props (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .scl_i(scl_i), .sda_o(sda_o),
  .sda_oe_o(sda_oe_o), .rd_req_o(rd_req_o), .busy_o(busy_o));

// [verification/serial_read_master.sv]
`timescale 1ns/100ps

// ----------------------------------------------------------------------
// bus master model, clock stands high between frames
// ----------------------------------------------------------------------
module serial_read_master #(
  parameter int T = 48
) (
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_low_o
);
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  task automatic tick(output logic s);
    #T scl_o = 1'b1;
    #T s = sda_i;
    #T scl_o = 1'b0;
    #T;
  endtask
  task automatic start();
    sda_low_o = 1'b0;
    #T scl_o = 1'b1;
    #T sda_low_o = 1'b1;
    #T scl_o = 1'b0;
    #T;
  endtask
  task automatic stop();
    sda_low_o = 1'b1;
    #T scl_o = 1'b1;
    #T sda_low_o = 1'b0;
    #T;
  endtask
  task automatic put(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      sda_low_o = !d[i];
      tick(s);
    end
    sda_low_o = 1'b0;
    tick(s);
    ack = !s;
  endtask
  task automatic get(input logic last, output logic [7:0] d);
    logic s;
    sda_low_o = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      tick(s);
      d[i] = s;
    end
    sda_low_o = !last;
    tick(s);
    sda_low_o = 1'b0;
  endtask
endmodule

// [verification/serial_read_target_tb_top.sv]
`timescale 1ns/100ps

// ----------------------------------------------------------------------
// bench top
// ----------------------------------------------------------------------
module serial_read_target_tb_top;
  localparam logic [6:0] ID_A = 7'h2A;
  localparam logic [6:0] ID_B = 7'h2B;
  logic                     clk_i = 1'b0;
  logic                     sys_rst_i = 1'b1;
  logic                     scl, sda_low, sda_o, sda_oe_o, busy_o;
  logic               [7:0] rd_data_i = 8'h00;
  serial_read_pkg::rd_req_t rd_req_o;
  int                       fail_count = 0;
  int                       num_checks = 0;
  int                       cycles = 0;
  wire logic                sda = !(sda_low || sda_oe_o);

  serial_read_master M (.sda_i(sda), .scl_o(scl), .sda_low_o(sda_low));
  serial_read_target #(.ID_CLOCK(ID_A), .ID_STORE(ID_B)) DUT (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .scl_clk_i(scl), .scl_i(scl),
    .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .rd_req_o(rd_req_o), .rd_data_i(rd_data_i), .busy_o(busy_o));

  function automatic logic [7:0] mem(logic [7:0] a, logic s);
    return a ^ (s ? 8'h3C : 8'hC3);
  endfunction

  always #5 clk_i = ~clk_i;
  always @(negedge clk_i) rd_data_i <= mem(rd_req_o.addr, rd_req_o.space);
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      report_and_stop();
    end
  end

  task automatic chk_byte(input logic [7:0] g, input logic [7:0] e,
                          input string w);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %0t %s got %h exp %h", $time, w, g, e);
    end
  endtask
  task automatic chk_bit(input logic g, input logic e, input string w);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %0t %s got %b exp %b", $time, w, g, e);
    end
  endtask
  task automatic idle_check();
    repeat (10) @(negedge clk_i);
    chk_bit(busy_o, 1'b0, "busy after stop");
    chk_bit(sda_oe_o, 1'b0, "line after stop");
  endtask
  task automatic current_read();
    logic       ack;
    logic [7:0] d;
    M.start();
    M.put({ID_A, 1'b1}, ack);
    chk_bit(ack, 1'b1, "read select ack");
    M.get(1'b1, d);
    chk_byte(d, mem(8'h00, 1'b0), "first byte");
    M.stop();
    idle_check();
  endtask
  task automatic bad_id();
    logic ack;
    M.start();
    M.put({7'h15, 1'b0}, ack);
    chk_bit(ack, 1'b0, "foreign select");
    M.stop();
    idle_check();
  endtask
  task automatic random_read(input logic [6:0] id, input logic [7:0] a,
                             input int n);
    logic       ack;
    logic [7:0] d;
    M.start();
    M.put({id, 1'b0}, ack);
    chk_bit(ack, 1'b1, "select ack");
    M.put(a, ack);
    chk_bit(ack, 1'b1, "address ack");
    M.start();
    M.put({id, 1'b1}, ack);
    chk_bit(ack, 1'b1, "read select ack");
    for (int i = 0; i < n; i++) begin
      M.get(i == n - 1, d);
      chk_byte(d, mem(a + i[7:0], id == ID_B), "data");
    end
    chk_bit(busy_o, 1'b0, "busy after nack");
    M.stop();
    idle_check();
  endtask

  task automatic address_only();
    logic ack;
    M.start();
    M.put({ID_B, 1'b0}, ack);
    chk_bit(ack, 1'b1, "store select ack");
    M.put(8'h5A, ack);
    chk_bit(ack, 1'b1, "address ack");
    chk_byte(rd_req_o.addr, 8'h5A, "pointer load");
    chk_bit(rd_req_o.space, 1'b1, "store space");
    M.stop();
    idle_check();
  endtask
  task automatic reset_midrun();
    sys_rst_i = 1'b1;
    repeat (2) @(negedge clk_i);
    sys_rst_i = 1'b0;
    repeat (3) @(negedge clk_i);
    chk_byte(rd_req_o.addr, 8'h00, "pointer after reset");
    chk_bit(busy_o, 1'b0, "busy after reset");
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    repeat (20) @(negedge clk_i);
    sys_rst_i = 1'b0;
    repeat (3) @(negedge clk_i);
    chk_byte(rd_req_o.addr, 8'h00, "pointer at reset");
    current_read();
    bad_id();
    random_read(ID_A, 8'h10, 3);
    random_read(ID_B, 8'hFE, 3);
    address_only();
    reset_midrun();
    current_read();
    report_and_stop();
  end
endmodule
